// ### hdl/floppy_status_register.v
// Floppy controller status word, command gate and AHB-Lite register slave
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "floppy_status_defines.vh"

module floppy_status_register #(
    parameter BYTE_TIME_CYCLES = (`BYTE_TIME_NS * 1000) / `CLK_PERIOD_PS
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output wire        irq,
    input  wire        master_reset_in,
    input  wire        ready_in,
    input  wire        write_protect_in_n,
    input  wire        head_load_timing_in,
    input  wire        track_zero_in_n,
    input  wire        index_pulse_in_n,
    input  wire        head_load_req,
    output reg         head_load_out,
    output reg         cmd_go,
    output reg  [2:0]  cmd_class,
    input  wire        cmd_done,
    input  wire        seek_error_set,
    input  wire        crc_error_set,
    input  wire        not_found_set,
    input  wire        deleted_mark_set,
    input  wire        write_fault_set,
    input  wire        byte_ready,
    input  wire [7:0]  disk_byte,
    output reg  [7:0]  host_byte,
    output reg         host_byte_valid,
    output reg         data_request_out
);

    localparam [31:0] BYTE_TIME = BYTE_TIME_CYCLES;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [5:0] pin_meta;
    reg  [5:0] pin_sync;

    // Drive pins are asynchronous; only the second stage is read
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= 6'h3e;
            pin_sync <= 6'h3e;
        end
        else
        begin
            pin_meta <= {index_pulse_in_n, track_zero_in_n, head_load_timing_in,
                         write_protect_in_n, ready_in, master_reset_in};
            pin_sync <= pin_meta;
        end
    end

    wire mrst_s  = pin_sync[0];
    wire ready_s = pin_sync[1];
    wire wprot_s = ~pin_sync[2];  // High means protected
    wire hdset_s = pin_sync[3];
    wire trk0_s  = ~pin_sync[4];  // High means at track 0
    wire index_s = ~pin_sync[5];  // High means index seen
    wire not_ready = ~ready_s | mrst_s;

    // ----------------------------------------
    // AHB-Lite address phase capture
    // ----------------------------------------
    reg        ph_valid;
    reg        ph_write;
    reg  [7:0] ph_addr;
    wire       addr_take = hsel & hready & htrans[1];
    wire       wr_strobe = ph_valid & ph_write;
    wire       rd_take   = addr_take & ~hwrite;

    // Zero wait states: every transfer ends one cycle after its address
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end
        else if (hready)
        begin
            ph_valid <= addr_take;
            ph_write <= hwrite;
            ph_addr  <= haddr;
        end
    end

    wire wr_ctrl = wr_strobe && ph_addr == `OFS_COMMAND_CTRL;
    wire wr_isr  = wr_strobe && ph_addr == `OFS_IRQ_STATUS;
    wire wr_mask = wr_strobe && ph_addr == `OFS_IRQ_MASK;
    wire wr_data = wr_strobe && ph_addr == `OFS_DATA_HOLDING;
    wire rd_data = rd_take && haddr == `OFS_DATA_HOLDING;

    // ----------------------------------------
    // Command gate and busy
    // ----------------------------------------
    reg        busy;
    wire       start_req = wr_ctrl & hwdata[`CTRL_START_BIT] & ~busy;
    wire       rw_class  = hwdata[2:0] != `CLS_POSITION;
    wire       refused   = start_req & rw_class & not_ready;
    wire       accepted  = start_req & ~refused;
    reg        refresh;

    // Busy rises with an accepted start and falls on the done pulse
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy      <= 1'b0;
            cmd_go    <= 1'b0;
            cmd_class <= `RST_CLASS;
            refresh   <= 1'b0;
        end
        else
        begin
            cmd_go  <= accepted;
            refresh <= accepted;
            if (accepted)
            begin
                busy      <= 1'b1;
                cmd_class <= hwdata[2:0];
            end
            else if (cmd_done)
            begin
                busy      <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Sticky condition flags
    // ----------------------------------------
    reg  seek_err;
    reg  crc_err;
    reg  not_found;
    reg  deleted;
    reg  wfault;
    reg  wp_hit;
    reg  lost;
    wire is_write = cmd_class == `CLS_WR_SECTOR || cmd_class == `CLS_WR_TRACK;

    // Each flag clears on refresh, but a set in that cycle wins
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seek_err  <= 1'b0;
            crc_err   <= 1'b0;
            not_found <= 1'b0;
            deleted   <= 1'b0;
            wfault    <= 1'b0;
            wp_hit    <= 1'b0;
        end
        else
        begin
            seek_err  <= seek_error_set | (seek_err & ~refresh);
            crc_err   <= crc_error_set | (crc_err & ~refresh);
            not_found <= not_found_set | (not_found & ~refresh);
            deleted   <= deleted_mark_set | (deleted & ~refresh);
            wfault    <= write_fault_set | (wfault & ~refresh);
            wp_hit    <= (busy & is_write & wprot_s) | (wp_hit & ~refresh);
        end
    end

    // ----------------------------------------
    // Data request and lost data timer
    // ----------------------------------------
    reg  [31:0] byte_timer;
    wire        serviced = wr_data | rd_data;
    wire        timeout  = data_request_out && byte_timer == BYTE_TIME - 32'h1;

    // Request stands until the host moves the byte, a byte time runs out or a new command is accepted
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_request_out <= 1'b0;
            byte_timer       <= 32'h0;
            lost             <= 1'b0;
            host_byte        <= 8'h00;
            host_byte_valid  <= 1'b0;
            head_load_out    <= 1'b0;
        end
        else
        begin
            head_load_out   <= head_load_req;
            host_byte_valid <= wr_data;
            if (wr_data)
                host_byte <= hwdata[7:0];
            if (byte_ready)
                data_request_out <= 1'b1;
            else if (serviced | timeout | refresh)
                data_request_out <= 1'b0;
            if (!data_request_out | byte_ready | serviced)
                byte_timer <= 32'h0;
            else
                byte_timer <= byte_timer + 32'h1;
            lost <= (timeout & ~serviced) | (lost & ~refresh);
        end
    end

    // ----------------------------------------
    // Status word composition
    // ----------------------------------------
    reg [7:0] next_status;

    // Bits with no meaning for the class stay at zero
    always @*
    begin
        next_status = 8'h00;
        next_status[`ST_NOT_READY] = not_ready;
        next_status[`ST_BUSY]      = busy;
        case (cmd_class)
            `CLS_POSITION:
            begin
                next_status[`ST_BIT6] = wprot_s;
                next_status[`ST_BIT5] = head_load_out & hdset_s;
                next_status[`ST_BIT4] = seek_err;
                next_status[`ST_BIT3] = crc_err;
                next_status[`ST_BIT2] = trk0_s;
                next_status[`ST_BIT1] = index_s;
            end
            `CLS_RD_ADDRESS:
            begin
                next_status[`ST_BIT4] = not_found;
                next_status[`ST_BIT3] = crc_err;
                next_status[`ST_BIT2] = lost;
                next_status[`ST_BIT1] = data_request_out;
            end
            `CLS_RD_SECTOR:
            begin
                next_status[`ST_BIT5] = deleted;
                next_status[`ST_BIT4] = not_found;
                next_status[`ST_BIT3] = crc_err;
                next_status[`ST_BIT2] = lost;
                next_status[`ST_BIT1] = data_request_out;
            end
            `CLS_RD_TRACK:
            begin
                next_status[`ST_BIT2] = lost;
                next_status[`ST_BIT1] = data_request_out;
            end
            `CLS_WR_SECTOR:
            begin
                next_status[`ST_BIT6] = wp_hit;
                next_status[`ST_BIT5] = wfault;
                next_status[`ST_BIT4] = not_found;
                next_status[`ST_BIT3] = crc_err;
                next_status[`ST_BIT2] = lost;
                next_status[`ST_BIT1] = data_request_out;
            end
            `CLS_WR_TRACK:
            begin
                next_status[`ST_BIT6] = wp_hit;
                next_status[`ST_BIT5] = wfault;
                next_status[`ST_BIT2] = lost;
                next_status[`ST_BIT1] = data_request_out;
            end
            default:
            begin
                next_status[`ST_BIT2] = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    reg  [`IRQ_WIDTH-1:0] irq_status;
    reg  [`IRQ_WIDTH-1:0] irq_mask;
    wire [`IRQ_WIDTH-1:0] irq_events = {byte_ready, timeout & ~serviced,
                                        refused, busy & cmd_done};
    wire [`IRQ_WIDTH-1:0] w1c = wr_isr ? hwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

    // Write one to clear; a new event in the same cycle stays set
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
            irq_mask   <= `RST_IRQ_MASK;
        end
        else
        begin
            irq_status <= irq_events | (irq_status & ~w1c);
            if (wr_mask)
                irq_mask <= hwdata[`IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [31:0] next_rdata;

    // Unmapped addresses read zero and still answer OKAY
    always @*
    begin
        case (haddr)
            `OFS_DISK_STATUS:  next_rdata = {24'h0, next_status};
            `OFS_COMMAND_CTRL: next_rdata = {23'h0, busy, 5'h0, cmd_class};
            `OFS_IRQ_STATUS:   next_rdata = {28'h0, irq_status};
            `OFS_IRQ_MASK:     next_rdata = {28'h0, irq_mask};
            `OFS_DATA_HOLDING: next_rdata = {24'h0, disk_byte};
            default:           next_rdata = 32'h0;
        endcase
    end

    // Sampled at the address phase so the data phase shows a stable word
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (rd_take)
            hrdata <= next_rdata;
    end

endmodule // floppy_status_register

// ### hdl/floppy_status_defines.vh
// Constants of the floppy status register block
`ifndef FLOPPY_STATUS_DEFINES_VH
`define FLOPPY_STATUS_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_DISK_STATUS   8'h00
`define OFS_COMMAND_CTRL  8'h04
`define OFS_IRQ_STATUS    8'h08
`define OFS_IRQ_MASK      8'h0c
`define OFS_DATA_HOLDING  8'h10

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define ST_NOT_READY   7
`define ST_BIT6        6
`define ST_BIT5        5
`define ST_BIT4        4
`define ST_BIT3        3
`define ST_BIT2        2
`define ST_BIT1        1
`define ST_BUSY        0

// ----------------------------------------
// Command classes (command_ctrl bits 2:0)
// ----------------------------------------
`define CLS_POSITION   3'h0
`define CLS_RD_ADDRESS 3'h1
`define CLS_RD_SECTOR  3'h2
`define CLS_RD_TRACK   3'h3
`define CLS_WR_SECTOR  3'h4
`define CLS_WR_TRACK   3'h5
`define CTRL_START_BIT 8

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_DONE       0
`define IRQ_REFUSED    1
`define IRQ_LOST       2
`define IRQ_REQUEST    3
`define IRQ_WIDTH      4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_IRQ_MASK   4'h0
`define RST_CLASS      3'h0
`define CLK_PERIOD_PS  5000
`define BYTE_TIME_NS   32000

`endif

// ### testbench/floppy_status_register_assertions.sv
// Port-level checks for the floppy status register
`timescale 1ns/1ps
module floppy_status_register_assertions #(
    parameter BYTE_TIME_CYCLES = 6400
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        ready_in,
    input wire        head_load_req,
    input wire        head_load_out,
    input wire        cmd_go,
    input wire [2:0]  cmd_class,
    input wire        byte_ready,
    input wire        data_request_out,
    input wire        host_byte_valid
);
    // ----
    // Unserviced request length
    // ----
    logic [15:0] req_run;
    wire         serve = hsel && htrans[1] && (haddr == 8'h10);
    // A service or a new byte restarts the count, so only an ignored request grows it
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            req_run <= 16'h0;
        else if (data_request_out && !serve && !byte_ready)
            req_run <= req_run + 16'h1;
        else
            req_run <= 16'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_go_pulse; cmd_go |=> !cmd_go; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("start pulse too long");
    property p_go_cause; cmd_go |-> $past(hsel && hwrite && htrans[1] && haddr == 8'h04, 2); endproperty
    a_go_cause: assert property (p_go_cause) else $error("start without command write");
    property p_go_ready; cmd_go && cmd_class != 3'h0 |-> $past(ready_in, 3); endproperty
    a_go_ready: assert property (p_go_ready) else $error("transfer started while not ready");
    property p_class; cmd_go |-> cmd_class == $past(hwdata[2:0], 1); endproperty
    a_class: assert property (p_class) else $error("class differs from written value");
    property p_head; $rose(head_load_req) |=> head_load_out; endproperty
    a_head: assert property (p_head) else $error("head load output late");
    property p_req_set; byte_ready |=> data_request_out; endproperty
    a_req_set: assert property (p_req_set) else $error("request not raised");
    property p_req_run; req_run <= BYTE_TIME_CYCLES; endproperty
    a_req_run: assert property (p_req_run) else $error("request outlived one byte time");
    property p_hbv; host_byte_valid |=> !host_byte_valid; endproperty
    a_hbv: assert property (p_hbv) else $error("host byte strobe too long");
    cover property (cmd_go && cmd_class == 3'h4);
    cover property ($fell(data_request_out) && !cmd_go);
    cover property (host_byte_valid);
endmodule // floppy_status_register_assertions
bind floppy_status_register floppy_status_register_assertions #(.BYTE_TIME_CYCLES(BYTE_TIME_CYCLES)) u_chk (.*);

// ### testbench/floppy_drive_model.sv
// Behavioural floppy drive: sense pins and head settle
`timescale 1ns/1ps
module floppy_drive_model #(
    parameter SETTLE = 4
) (
    input  wire hclk,
    input  wire head_load_out,
    input  wire drv_ready,
    input  wire drv_protect,
    input  wire drv_trk0,
    input  wire drv_index,
    output wire ready_in,
    output wire write_protect_in_n,
    output wire track_zero_in_n,
    output wire index_pulse_in_n,
    output reg  head_load_timing_in = 1'b0
);
    // Protect, track zero and index sense lines are active low; ready is active high
    assign ready_in = drv_ready;
    assign write_protect_in_n = !drv_protect;
    assign track_zero_in_n = !drv_trk0;
    assign index_pulse_in_n = !drv_index;
    // Head engages only after settling; unloading frees it at once
    integer cnt = 0;
    always @(posedge hclk)
    begin
        cnt <= head_load_out ? cnt + 1 : 0;
        head_load_timing_in <= head_load_out && (cnt >= SETTLE);
    end
endmodule // floppy_drive_model

// ### testbench/floppy_status_register_tb.sv
// Self-checking bench for the floppy status register
`timescale 1ns/1ps
module floppy_status_register_tb;
    // ----
    // Signals
    // ----
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, master_reset_in = 0, head_load_req = 0;
    logic [7:0] haddr = 8'h00, disk_byte = 8'h5a;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, d;
    logic [6:0] ev = 7'h00;
    logic drv_ready = 1, drv_protect = 0, drv_trk0 = 0, drv_index = 0;
    wire byte_ready, cmd_done, seek_error_set, crc_error_set, not_found_set, deleted_mark_set, write_fault_set;
    wire hreadyout, hresp, irq, head_load_out, cmd_go, host_byte_valid, data_request_out;
    wire ready_in, write_protect_in_n, head_load_timing_in, track_zero_in_n, index_pulse_in_n;
    wire [31:0] hrdata;
    wire [2:0] cmd_class;
    wire [7:0] host_byte;
    wire hready = hreadyout;
    int num_errors = 0, check_count = 0;
    logic [7:0] sweep_exp [7] = '{8'h58, 8'h18, 8'h38, 8'h00, 8'h78, 8'h60, 8'h00};
    assign {byte_ready, cmd_done, seek_error_set, crc_error_set, not_found_set, deleted_mark_set, write_fault_set} = ev;
    floppy_status_register #(.BYTE_TIME_CYCLES(16)) dut (.*);
    floppy_drive_model drive (.*);
    initial
        forever #2.5 hclk = ~hclk;
    // ----
    // Shared tasks
    // ----
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // One single transfer; waits on hready with no assumed latency
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'h2};
        do @(posedge hclk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task st(input logic [7:0] e);
        xfer(0, 8'h00, 0);
        chk("disk_status", {24'h0, e}, d);
    endtask
    task start(input logic [2:0] c);
        xfer(1, 8'h04, {23'h0, 1'b1, 5'h0, c});
    endtask
    // Core events last exactly one cycle
    task pulse(input logic [6:0] m);
        @(posedge hclk);
        ev <= m;
        @(posedge hclk);
        ev <= 7'h00;
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        st(8'h00);
        chk("irq", 0, irq);
        chk("hresp", 0, hresp);
        chk("hreadyout", 1, hreadyout);
        xfer(0, 8'h0c, 0);
        chk("irq_mask", 0, d);
        xfer(0, 8'h20, 0);
        chk("unmapped", 0, d);
    endtask
    task t_pins;
        {drv_ready, drv_protect, drv_trk0, drv_index, head_load_req} <= 5'h0f;
        tick(12);
        st(8'he6);
        {drv_ready, drv_protect, drv_trk0, drv_index, head_load_req, master_reset_in} <= 6'h21;
        tick(12);
        st(8'h80);
        master_reset_in <= 0;
        tick(6);
        st(8'h00);
    endtask
    // Refused start also exercises the interrupt mask and clear
    task t_refuse;
        drv_ready <= 0;
        tick(6);
        start(3'h2);
        tick(3);
        st(8'h80);
        xfer(0, 8'h08, 0);
        chk("irq_status", 32'h2, d);
        xfer(1, 8'h0c, 32'h2);
        tick(1);
        chk("irq", 1, irq);
        xfer(1, 8'h08, 32'h2);
        tick(1);
        chk("irq", 0, irq);
        drv_ready <= 1;
        tick(6);
    endtask
    task t_sweep;
        drv_protect <= 1;
        for (int c = 0; c < 7; c++)
        begin
            start(c[2:0]);
            tick(2);
            st((c == 0 || c == 4 || c == 5) ? 8'h41 : 8'h01);
            xfer(0, 8'h04, 0);
            chk("command_ctrl", {23'h0, 1'b1, 5'h0, c[2:0]}, d);
            pulse(7'h1f);
            tick(2);
            st(sweep_exp[c] | 8'h01);
            pulse(7'h20);
            tick(3);
            st(sweep_exp[c]);
        end
    endtask
    task t_data;
        drv_protect <= 0;
        start(3'h2);
        pulse(7'h40);
        tick(1);
        chk("data_request_out", 1, data_request_out);
        st(8'h03);
        xfer(0, 8'h10, 0);
        chk("disk_byte", 32'h5a, d);
        pulse(7'h40);
        tick(15);
        chk("data_request_out", 1, data_request_out);
        tick(2);
        chk("data_request_out", 0, data_request_out);
        st(8'h05);
        xfer(0, 8'h08, 0);
        chk("irq_lost", 32'h4, d & 32'h4);
        pulse(7'h20);
        tick(3);
        start(3'h4);
        tick(2);
        st(8'h01);
        xfer(1, 8'h10, 32'ha5);
        tick(2);
        chk("host_byte", 32'ha5, host_byte);
        pulse(7'h20);
    endtask
    task report_and_stop;
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Run is a few hundred cycles; the watchdog allows far more
    initial
    begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        report_and_stop;
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        t_reset;
        t_pins;
        t_refuse;
        t_sweep;
        t_data;
        report_and_stop;
    end
endmodule // floppy_status_register_tb
